// ===== core/lrrc_top.sv
// Purpose: result and range configuration registers of a light sensor behind a two-wire serial slave
// Assumes: light_level_i is a linear light code from on-chip logic on sys_clk_i, 0.01 lux per step
// Notes:   scl/sda come from pins and pass two flops; sda is open drain, enable low while pulling low
`timescale 1ns/10ps
`default_nettype none

module lrrc_top
    import lrrc_pkg::*;
#(
    parameter logic [6:0]  DEV_ADDR     = 7'h2A, // arbitrary slave address
    parameter int          RAW_W        = 24,
    parameter int unsigned SHORT_CYCLES = LRRC_CT_SHORT_CYC,
    parameter int unsigned LONG_CYCLES  = LRRC_CT_LONG_CYC
) (
    input  wire logic             sys_clk_i,
    input  wire logic             resetn_i,
    input  wire logic             scl_i,
    input  wire logic             sda_i,
    output var  logic             sda_o,
    output var  logic             sda_oe_n_o,
    input  wire logic [RAW_W-1:0] light_level_i,
    output var  logic             conv_active_o,
    output var  logic             conv_done_o
);
    // elaboration checks on parameters the logic cannot serve
    if (RAW_W < 12 || RAW_W > 32) begin : g_bad_raw
        $error("RAW_W out of range");
    end
    if (SHORT_CYCLES < 2 || LONG_CYCLES < 2 || LONG_CYCLES >= (1 << LRRC_TIMER_W)) begin : g_bad_time
        $error("conversion cycle counts out of range");
    end
    lrrc_state_s             st;
    lrrc_state_s             nx;
    logic                    scl_rise;
    logic                    scl_fall;
    logic                    bus_start;
    logic                    bus_stop;
    logic [15:0]             rd_word;
    logic [LRRC_TIMER_W-1:0] conv_len;
    logic                    wr_commit;
    logic [15:0]             wdata;
    logic                    tx_load;
    logic                    crf_clear;
    logic [3:0]              conv_exp;
    logic [12:0]             conv_scaled;
    // smallest range whose mantissa still fits, top range when none fits
    function automatic logic [3:0] auto_exp(input logic [RAW_W-1:0] raw);
        logic [3:0] e;
        e = LRRC_RANGE_MAX;
        for (int i = int'(LRRC_RANGE_MAX); i >= 0; i--) begin
            if ((raw >> i) <= RAW_W'(LRRC_MANT_FULL)) begin
                e = 4'(i);
            end
        end
        return e;
    endfunction
    // {overflow, mantissa}; saturates at full scale
    function automatic logic [12:0] scale(input logic [RAW_W-1:0] raw, input logic [3:0] e);
        logic [RAW_W-1:0] s;
        s = raw >> e;
        if (s > RAW_W'(LRRC_MANT_FULL)) begin
            return {1'b1, LRRC_MANT_FULL};
        end
        return {1'b0, s[11:0]};
    endfunction

    // bus events from synchronised pins; first sync stage stays private
    assign scl_rise  = st.scl_s & ~st.scl_q;
    assign scl_fall  = ~st.scl_s & st.scl_q;
    assign bus_start = st.scl_s & st.scl_q & st.sda_q & ~st.sda_s;
    assign bus_stop  = st.scl_s & st.scl_q & ~st.sda_q & st.sda_s;
    assign rd_word   = (st.ptr == LRRC_PTR_RESULT) ? 16'(st.result)
                     : (st.ptr == LRRC_PTR_CONFIG) ? 16'(st.cfg) : 16'h0000; // unmapped pointers read zero
    assign conv_len  = st.cfg.conversion_time ? LRRC_TIMER_W'(LONG_CYCLES - 1)
                                              : LRRC_TIMER_W'(SHORT_CYCLES - 1);
    // reserved range codes fall back to automatic ranging
    assign conv_exp    = (st.cfg.range_select >= LRRC_RANGE_AUTO) ? auto_exp(light_level_i)
                                                                  : st.cfg.range_select;
    assign conv_scaled = scale(light_level_i, conv_exp);
    // next-state logic: serial slave, register file, conversion engine
    always_comb begin
        nx        = st;
        wr_commit = 1'b0;
        wdata     = 16'h0000;
        tx_load   = 1'b0;
        crf_clear = 1'b0;
        nx.scl_m  = scl_i;
        nx.scl_s  = st.scl_m;
        nx.scl_q  = st.scl_s;
        nx.sda_m  = sda_i;
        nx.sda_s  = st.sda_m;
        nx.sda_q  = st.sda_s;
        nx.done   = 1'b0;
        // start and stop override any byte in flight
        if (bus_start) begin
            nx.bus      = LRRC_ADDR;
            nx.bitcnt   = 4'h0;
            nx.wbyte    = 2'h0;
            nx.sda_oe_n = 1'b1;
        end else if (bus_stop) begin
            nx.bus      = LRRC_IDLE;
            nx.sda_oe_n = 1'b1;
        end else begin
            case (st.bus)
                LRRC_ADDR, LRRC_WRX: begin
                    if (scl_rise && st.bitcnt < LRRC_BITS_BYTE) begin
                        nx.shift  = {st.shift[6:0], st.sda_s};
                        nx.bitcnt = st.bitcnt + 4'h1;
                    end else if (scl_fall && st.bitcnt == LRRC_BITS_BYTE) begin
                        nx.bus      = LRRC_WACK;
                        nx.sda_oe_n = 1'b0;
                        if (st.bus == LRRC_ADDR) begin
                            nx.rw       = st.shift[0];
                            nx.byte_sel = 1'b0;
                            if (st.shift[7:1] != DEV_ADDR) begin
                                nx.bus      = LRRC_IDLE;
                                nx.sda_oe_n = 1'b1;
                            end
                        end else begin
                            // pointer byte, then msb, then lsb pairs
                            case (st.wbyte)
                                2'h0: begin
                                    nx.ptr   = st.shift;
                                    nx.wbyte = 2'h1;
                                end
                                2'h1: begin
                                    nx.msb   = st.shift;
                                    nx.wbyte = 2'h2;
                                end
                                default: begin
                                    nx.wbyte  = 2'h1;
                                    wdata     = {st.msb, st.shift};
                                    // result pointer write is dropped here
                                    wr_commit = (st.ptr == LRRC_PTR_CONFIG);
                                end
                            endcase
                        end
                    end
                end
                LRRC_WACK: begin
                    if (scl_fall) begin
                        nx.bitcnt   = 4'h0;
                        nx.sda_oe_n = 1'b1;
                        nx.bus      = LRRC_WRX;
                        tx_load     = st.rw;
                    end
                end
                LRRC_TX: begin
                    if (scl_fall) begin
                        if (st.bitcnt == LRRC_BITS_BYTE) begin
                            nx.sda_oe_n = 1'b1;
                            nx.bus      = LRRC_RACK;
                        end else begin
                            nx.shift    = {st.shift[6:0], 1'b0};
                            nx.sda_oe_n = st.shift[6];
                            nx.bitcnt   = st.bitcnt + 4'h1;
                        end
                    end
                end
                LRRC_RACK: begin
                    if (scl_rise) begin
                        nx.nack = st.sda_s;
                    end else if (scl_fall) begin
                        nx.bus  = LRRC_IDLE;
                        tx_load = ~st.nack;
                    end
                end
                default: begin
                    nx.bus = LRRC_IDLE;
                end
            endcase
        end
        // word latched at msb so both bytes of a pair agree
        if (tx_load) begin
            nx.shift    = st.byte_sel ? st.txword[7:0] : rd_word[15:8];
            nx.sda_oe_n = st.byte_sel ? st.txword[7] : rd_word[15];
            nx.bitcnt   = 4'h1;
            nx.bus      = LRRC_TX;
            nx.byte_sel = ~st.byte_sel;
            if (!st.byte_sel) begin
                nx.txword = rd_word;
                crf_clear = (st.ptr == LRRC_PTR_CONFIG);
            end
        end
        // reading the configuration clears ready; a finish in the same cycle wins below
        if (crf_clear) begin
            nx.cfg.conversion_ready_flag = 1'b0;
        end
        // a write aborts, and restarts unless the new mode is shutdown; flags 8..5 keep their values
        if (wr_commit) begin
            nx.cfg    = lrrc_cfg_s'((wdata & LRRC_CFG_WMASK) | (st.cfg & ~LRRC_CFG_WMASK));
            nx.timer  = '0;
            nx.active = (nx.cfg.mode != LRRC_MODE_SHUT);
        end else if (st.active) begin
            if (st.timer == conv_len) begin
                nx.done                      = 1'b1;
                nx.timer                     = '0;
                nx.result.mantissa           = conv_scaled[11:0];
                nx.result.exponent           = (st.cfg.exponent_mask && st.cfg.range_select < LRRC_RANGE_AUTO)
                                               ? 4'h0 : conv_exp;
                nx.cfg.overflow_flag         = conv_scaled[12];
                nx.cfg.conversion_ready_flag = 1'b1;
                if (st.cfg.mode == LRRC_MODE_SINGLE) begin
                    nx.cfg.mode = LRRC_MODE_SHUT;
                    nx.active   = 1'b0;
                end
            end else begin
                nx.timer = st.timer + 1'b1;
            end
        end
    end

    // single state register; power-on value is the documented default
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st <= LRRC_STATE_RESET;
        end else begin
            st <= nx;
        end
    end

    assign sda_o         = st.sda_out;
    assign sda_oe_n_o    = st.sda_oe_n;
    assign conv_active_o = st.active;
    assign conv_done_o   = st.done;

    // checks on the conversion engine and register file
    property p_mask_exp;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        st.done && st.cfg.exponent_mask && st.cfg.range_select < LRRC_RANGE_AUTO |-> st.result.exponent == 4'h0;
    endproperty
    a_mask_exp: assert property (p_mask_exp) else $error("masked exponent not zero");
    property p_manual_exp;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        st.done && !st.cfg.exponent_mask && st.cfg.range_select < LRRC_RANGE_AUTO
        |-> st.result.exponent == st.cfg.range_select;
    endproperty
    a_manual_exp: assert property (p_manual_exp) else $error("manual range not in exponent");
    property p_auto_exp;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        st.done && st.cfg.range_select == LRRC_RANGE_AUTO |-> st.result.exponent <= LRRC_RANGE_MAX;
    endproperty
    a_auto_exp: assert property (p_auto_exp) else $error("auto range exponent out of table");
    property p_single_end;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        st.done && $past(st.cfg.mode) == LRRC_MODE_SINGLE |-> st.cfg.mode == LRRC_MODE_SHUT && !st.active;
    endproperty
    a_single_end: assert property (p_single_end) else $error("single shot did not shut down");
    property p_result_hold;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        !st.done |-> $stable(st.result);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result changed without a finish");
    property p_ro_flags;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        wr_commit |=> st.cfg.overflow_flag == $past(st.cfg.overflow_flag)
                      && st.cfg.conversion_ready_flag == $past(st.cfg.conversion_ready_flag);
    endproperty
    a_ro_flags: assert property (p_ro_flags) else $error("write changed a read-only flag");
    property p_abort;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        wr_commit |=> st.timer == '0 && !st.done && st.active == (st.cfg.mode != LRRC_MODE_SHUT);
    endproperty
    a_abort: assert property (p_abort) else $error("write did not abort and restart");
    property p_period;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        st.done |-> $past(st.timer) == $past(conv_len) && $past(st.active);
    endproperty
    a_period: assert property (p_period) else $error("conversion length wrong");

endmodule

`default_nettype wire

// ===== inc/lrrc_pkg.sv
// Purpose: shared types and constants for the light result and range configuration block
// Assumes: 100 MHz system clock, 16-bit registers reached by an 8-bit register pointer
// Notes:   configuration struct mirrors the register bit layout, msb first
package lrrc_pkg;

    // register pointers
    localparam logic [7:0]  LRRC_PTR_RESULT = 8'h00;
    localparam logic [7:0]  LRRC_PTR_CONFIG = 8'h01;

    // host-writable configuration bits: 15..9 and 4..0
    localparam logic [15:0] LRRC_CFG_WMASK  = 16'hFE1F;
    localparam logic [15:0] LRRC_CFG_RESET  = 16'hC810;

    // range codes
    localparam logic [3:0]  LRRC_RANGE_AUTO = 4'hC;
    localparam logic [3:0]  LRRC_RANGE_MAX  = 4'hB;
    localparam logic [11:0] LRRC_MANT_FULL  = 12'hFFF;

    // conversion modes
    localparam logic [1:0]  LRRC_MODE_SHUT   = 2'h0;
    localparam logic [1:0]  LRRC_MODE_SINGLE = 2'h1;

    // conversion times
    localparam int unsigned LRRC_CLK_HZ      = 100_000_000;
    localparam int unsigned LRRC_CT_SHORT_MS = 100;
    localparam int unsigned LRRC_CT_LONG_MS  = 800;
    localparam int unsigned LRRC_CT_SHORT_CYC = (LRRC_CLK_HZ / 1000) * LRRC_CT_SHORT_MS;
    localparam int unsigned LRRC_CT_LONG_CYC  = (LRRC_CLK_HZ / 1000) * LRRC_CT_LONG_MS;
    localparam int          LRRC_TIMER_W     = 27;

    // serial bus bit counts
    localparam logic [3:0]  LRRC_BITS_BYTE  = 4'h8;

    typedef struct packed {
        logic [3:0] range_select;
        logic       conversion_time;
        logic [1:0] mode;
        logic       overflow_flag;
        logic       conversion_ready_flag;
        logic       over_high_limit;
        logic       under_low_limit;
        logic       latch_mode;
        logic       polarity;
        logic       exponent_mask;
        logic [1:0] fault_count;
    } lrrc_cfg_s;

    typedef struct packed {
        logic [3:0]  exponent;
        logic [11:0] mantissa;
    } lrrc_result_s;

    typedef enum logic [5:0] {
        LRRC_IDLE = 6'h01,
        LRRC_ADDR = 6'h02,
        LRRC_WACK = 6'h04,
        LRRC_WRX  = 6'h08,
        LRRC_TX   = 6'h10,
        LRRC_RACK = 6'h20
    } lrrc_bus_e;

    typedef struct packed {
        logic                    scl_m;
        logic                    scl_s;
        logic                    scl_q;
        logic                    sda_m;
        logic                    sda_s;
        logic                    sda_q;
        lrrc_bus_e               bus;
        logic [3:0]              bitcnt;
        logic [7:0]              shift;
        logic                    rw;
        logic [1:0]              wbyte;
        logic [7:0]              msb;
        logic [7:0]              ptr;
        logic [15:0]             txword;
        logic                    byte_sel;
        logic                    nack;
        logic                    sda_out;
        logic                    sda_oe_n;
        lrrc_cfg_s               cfg;
        lrrc_result_s            result;
        logic                    active;
        logic                    done;
        logic [LRRC_TIMER_W-1:0] timer;
    } lrrc_state_s;

    localparam lrrc_state_s LRRC_STATE_RESET = '{
        scl_m: 1'b1, scl_s: 1'b1, scl_q: 1'b1,
        sda_m: 1'b1, sda_s: 1'b1, sda_q: 1'b1,
        bus: LRRC_IDLE, sda_oe_n: 1'b1,
        cfg: lrrc_cfg_s'(LRRC_CFG_RESET),
        default: '0
    };

endpackage

// ===== tb/lrrc_host.sv
// Purpose: two-wire bus master model that reaches the sensor registers
// Assumes: pull-up on the data line, 16 system clocks per bus bit
// Notes:   lines change just after a clock edge; reads pulse rd_valid_o
`timescale 1ns/10ps
`default_nettype none

module lrrc_host #(
    parameter logic [6:0] ADDR = 7'h2A
) (
    input  wire logic        sys_clk_i,
    input  wire logic        sda_i,
    output var  logic        scl_o,
    output var  logic        sda_o,
    output var  logic [15:0] rd_data_o,
    output var  logic        rd_valid_o,
    output var  logic [7:0]  nacks_o
);
    // idle bus: both lines released
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
        rd_data_o = 16'h0000;
        rd_valid_o = 1'b0;
        nacks_o = 8'h00;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask

    // data moves only while scl is low; sampled mid high phase
    task automatic put_bit(input logic b, output logic s);
        sda_o = b;
        tick(4);
        scl_o = 1'b1;
        tick(4);
        s = sda_i;
        tick(4);
        scl_o = 1'b0;
        tick(4);
    endtask

    // also serves as repeated start when scl is low
    task automatic start();
        sda_o = 1'b1;
        tick(4);
        scl_o = 1'b1;
        tick(4);
        sda_o = 1'b0;
        tick(4);
        scl_o = 1'b0;
        tick(4);
    endtask

    task automatic stop();
        sda_o = 1'b0;
        tick(4);
        scl_o = 1'b1;
        tick(4);
        sda_o = 1'b1;
        tick(4);
    endtask

    // byte msb first, then the ack bit; chk counts a missing device ack
    task automatic put_byte(input logic [7:0] d, input logic ack, input logic chk, output logic [7:0] q);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i], s);
            q[i] = s;
        end
        put_bit(ack, s);
        nacks_o = nacks_o + 8'(chk & s);
    endtask

    task automatic write_reg(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d);
        logic [7:0] q;
        start();
        put_byte({a, 1'b0}, 1'b1, 1'b1, q);
        put_byte(p, 1'b1, 1'b1, q);
        put_byte(d[15:8], 1'b1, 1'b1, q);
        put_byte(d[7:0], 1'b1, 1'b1, q);
        stop();
    endtask

    // pointer write, repeated start, two bytes, master nack on the last
    task automatic read_reg(input logic [7:0] p);
        logic [7:0] hi;
        logic [7:0] lo;
        start();
        put_byte({ADDR, 1'b0}, 1'b1, 1'b1, hi);
        put_byte(p, 1'b1, 1'b1, hi);
        start();
        put_byte({ADDR, 1'b1}, 1'b1, 1'b1, hi);
        put_byte(8'hFF, 1'b0, 1'b0, hi);
        put_byte(8'hFF, 1'b1, 1'b0, lo);
        stop();
        rd_data_o = {hi, lo};
        rd_valid_o = 1'b1;
        tick(1);
        rd_valid_o = 1'b0;
    endtask
endmodule

`default_nettype wire

// ===== tb/lrrc_top_test.sv
// Purpose: self-checking bench for the light result and range configuration block
// Assumes: shortened conversion counts; bus traffic through lrrc_host
// Notes:   read words are compared by a monitor against a queue of expected words
`timescale 1ns/10ps
`default_nettype none

module lrrc_top_test;
    import lrrc_pkg::*;
    localparam int         SHORT = 1000;
    localparam int         LONG  = 3000;
    localparam logic [6:0] DEV   = 7'h2A;
    logic        sys_clk = 1'b0;
    logic        resetn;
    logic [23:0] light;
    logic        scl;
    logic        hsda;
    logic        sda_o;
    logic        sda_oe_n;
    logic        conv_active;
    logic        conv_done;
    logic [15:0] rd_data;
    logic        rd_valid;
    logic [7:0]  nacks;
    wire  logic  sda_wire;
    int          fails = 0;
    int          checked = 0;
    int          dones = 0;
    logic [15:0] expq[$];
    logic [15:0] lfsr_st = 16'h0050;

    // open drain with pull-up: low if either party pulls
    assign sda_wire = hsda & (sda_oe_n ? 1'b1 : sda_o);

    initial forever #5 sys_clk = ~sys_clk;

    lrrc_top #(.DEV_ADDR(DEV), .SHORT_CYCLES(SHORT), .LONG_CYCLES(LONG)) i_dut (
        .sys_clk_i(sys_clk), .resetn_i(resetn), .scl_i(scl), .sda_i(sda_wire),
        .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .light_level_i(light),
        .conv_active_o(conv_active), .conv_done_o(conv_done));

    lrrc_host #(.ADDR(DEV)) i_host (
        .sys_clk_i(sys_clk), .sda_i(sda_wire), .scl_o(scl), .sda_o(hsda),
        .rd_data_o(rd_data), .rd_valid_o(rd_valid), .nacks_o(nacks));

    function automatic logic [15:0] lfsr_next();
        lfsr_st = {lfsr_st[14:0], lfsr_st[15] ^ lfsr_st[13] ^ lfsr_st[12] ^ lfsr_st[10]};
        return lfsr_st;
    endfunction

    // auto picks the smallest exponent that fits; mask zeroes manual exponents
    function automatic logic [15:0] exp_result(input logic [3:0] rs, input logic me,
                                               input logic [23:0] lv, output logic ovf);
        int          e;
        logic [23:0] m;
        e = rs;
        if (rs == LRRC_RANGE_AUTO)
            for (e = 0; e < 11 && (lv >> e) > 24'h000FFF; e++);
        m = lv >> e;
        ovf = m > 24'h000FFF;
        if (ovf) m = 24'h000FFF;
        if (me && rs < LRRC_RANGE_AUTO) e = 0;
        return {e[3:0], m[11:0]};
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic expect_read(input logic [7:0] p, input logic [15:0] exp);
        expq.push_back(exp);
        i_host.read_reg(p);
    endtask

    task automatic wait_done(output int cyc);
        cyc = 0;
        do begin
            @(posedge sys_clk);
            #1;
            cyc++;
        end while (conv_done !== 1'b1 && cyc < 2 * LONG);
    endtask

    // oldest expected word against each finished read
    always @(negedge sys_clk) begin // falling edge, clear of the launching edge
        if (conv_done === 1'b1) dones++;
        if (rd_valid === 1'b1) begin
            if (expq.size() > 0) check(rd_data, expq.pop_front(), "read word");
            else check(16'h0000, 16'hFFFF, "read with nothing expected");
        end
    end

    // watchdog sized well above the expected run length
    initial begin
        repeat (100_000) @(posedge sys_clk);
        fails++;
        $display("unexpected at %0t: watchdog expired", $time);
        stop_test();
    end

    initial begin
        int          cyc;
        int          n;
        logic [15:0] w;
        logic [15:0] r;
        logic [23:0] lv;
        logic        ovf;
        logic [3:0]  rs;
        logic        me;
        resetn = 1'b0;
        light = 24'h000000;
        repeat (3) @(posedge sys_clk);
        #1;
        resetn = 1'b1;
        expect_read(LRRC_PTR_CONFIG, LRRC_CFG_RESET);
        expect_read(LRRC_PTR_RESULT, 16'h0000);
        expect_read(8'h02, 16'h0000);
        // flag bits must not take host data
        i_host.write_reg(DEV, LRRC_PTR_CONFIG, 16'h01E0);
        expect_read(LRRC_PTR_CONFIG, 16'h0000);
        check({15'h0000, conv_active}, 16'h0000, "active in shutdown");
        i_host.write_reg(7'h2B, LRRC_PTR_CONFIG, 16'h0000);
        // every manual range and auto; reserved codes are never sent
        for (int e = 0; e <= 12; e++) begin
            rs = 4'(e);
            me = rs[0];
            w = lfsr_next();
            lv = 24'({lfsr_next(), lfsr_next()}) >> w[3:0];
            light = lv;
            i_host.write_reg(DEV, LRRC_PTR_CONFIG, {rs, 1'b0, LRRC_MODE_SINGLE, 4'h0, 2'h0, me, 2'h0});
            wait_done(cyc);
            r = exp_result(rs, me, lv, ovf);
            expect_read(LRRC_PTR_RESULT, r);
            expect_read(LRRC_PTR_CONFIG, {rs, 1'b0, LRRC_MODE_SHUT, ovf, 1'b1, 4'h0, me, 2'h0});
        end
        i_host.write_reg(DEV, LRRC_PTR_RESULT, 16'hFFFF);
        expect_read(LRRC_PTR_RESULT, r);
        // long conversion aborted by a short one, then by shutdown: a single finish
        dones = 0;
        i_host.write_reg(DEV, LRRC_PTR_CONFIG, 16'hCA00);
        i_host.write_reg(DEV, LRRC_PTR_CONFIG, 16'hC200);
        wait_done(cyc);
        check(16'(cyc > SHORT - 60 && cyc <= SHORT), 16'h0001, "restart length");
        tick(LONG);
        i_host.write_reg(DEV, LRRC_PTR_CONFIG, 16'hCA00);
        i_host.write_reg(DEV, LRRC_PTR_CONFIG, 16'hC800);
        tick(LONG + 100);
        check({conv_active, 15'(dones)}, 16'h0001, "abort or shutdown");
        for (int ct = 0; ct < 2; ct++) begin
            i_host.write_reg(DEV, LRRC_PTR_CONFIG, ct ? 16'hCA00 : 16'hC200);
            check({15'h0000, conv_active}, 16'h0001, "no conversion started");
            wait_done(cyc);
            n = ct ? LONG : SHORT;
            check(16'(cyc > n - 60 && cyc <= n), 16'h0001, "conversion length");
        end
        // both continuous codes repeat at the conversion period
        for (int m = 0; m < 2; m++) begin
            i_host.write_reg(DEV, LRRC_PTR_CONFIG, 16'hC400 | 16'(m << 9));
            wait_done(cyc);
            wait_done(cyc);
            check(16'(cyc), 16'(SHORT), "continuous period");
        end
        i_host.write_reg(DEV, LRRC_PTR_CONFIG, 16'hC800);
        check({8'h00, nacks}, 16'h0004, "ack count");
        tick(10);
        check(16'(expq.size()), 16'h0000, "reads left unanswered");
        stop_test();
    end
endmodule

`default_nettype wire
